// ### design/tsp_if.sv
// Purpose: Three-wire link between sensor port and master.
// Assumes: Data pin is pulled high when nobody drives it.
// Notes: The shared pin level is resolved here from both enables.
`timescale 1ns/1ns
interface tsp_if;
  logic cs_n;
  logic serial_clock_in;
  logic dev_sio_out;
  logic dev_sio_oe_n;
  logic mst_sio_out;
  logic mst_sio_oe_n;
  logic sio_level;
  assign sio_level = !dev_sio_oe_n ? dev_sio_out :
                     !mst_sio_oe_n ? mst_sio_out : 1'b1;
  modport device (
    input cs_n,
    input serial_clock_in,
    input sio_level,
    output dev_sio_out,
    output dev_sio_oe_n
  );
  modport master (
    output cs_n,
    output serial_clock_in,
    output mst_sio_out,
    output mst_sio_oe_n,
    input sio_level
  );
endinterface

// ### design/tsp_master.sv
// Purpose: Master end of the three-wire link with a register port.
// Assumes: Software writes only the defined mode codes.
// Notes: Link clock is generated by a divider of clk.
`timescale 1ns/1ns
module tsp_master (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  tsp_if.master link
);
  import tsp_pkg::*;

  tsp_state_t state_ff;
  logic [7:0] tmr_ff;
  logic [5:0] bit_ff;
  logic full_ff;
  logic [7:0] mode_ff;
  logic [15:0] rx_ff;
  logic [15:0] rxd_ff;
  logic done_ff;
  logic cs_n_ff;
  logic sck_ff;
  logic out_ff;
  logic oe_n_ff;
  logic [31:0] rdata_ff;
  logic s_sio;

  tsp_sync #(.W(1), .INIT(1'b1)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .d(link.sio_level),
    .q(s_sio)
  );

  wire busy = state_ff != TSP_IDLE;
  wire wr_ctrl = wr && addr == REG_CTRL;
  wire start = wr_ctrl && wdata[CTRL_START] && !busy;
  wire tmr_out = tmr_ff == 8'd0;
  wire [5:0] nbits = full_ff ? 6'(FRAME_BITS) : 6'(WORD_BITS);
  wire [5:0] bit_nxt = bit_ff + 6'd1;
  wire last_bit = bit_nxt == nbits;
  wire in_tx = bit_ff < 6'(WORD_BITS);
  wire [3:0] wsel = 4'(bit_nxt - 6'(WORD_BITS));
  wire [15:0] wword = {mode_ff, mode_ff};
  wire [31:0] stat = {30'd0, done_ff, busy};
  wire [31:0] rmux = addr == REG_CTRL ? {30'd0, full_ff, 1'b0} :
                     addr == REG_MODE ? {24'd0, mode_ff} :
                     addr == REG_RXD ? {16'd0, rxd_ff} :
                     addr == REG_STAT ? stat : 32'd0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= CONVERT_CODE;
      full_ff <= 1'b0;
      rdata_ff <= '0;
    end else if (ce) begin
      if (wr && addr == REG_MODE) begin
        mode_ff <= wdata[7:0];
      end
      if (wr_ctrl && !busy) begin
        full_ff <= wdata[CTRL_FULL];
      end
      rdata_ff <= rd ? rmux : 32'd0;
    end
  end

  // Done is sticky; a new finish wins over a read that clears it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == TSP_END && tmr_out) begin
        done_ff <= 1'b1;
      end else if (rd && addr == REG_STAT) begin
        done_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= TSP_IDLE;
      tmr_ff <= '0;
      bit_ff <= '0;
      rx_ff <= '0;
      rxd_ff <= '0;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      out_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else if (ce) begin
      if (!tmr_out) begin
        tmr_ff <= tmr_ff - 8'd1;
      end
      case (state_ff)
        TSP_IDLE: begin
          if (start) begin
            cs_n_ff <= 1'b0;
            bit_ff <= '0;
            tmr_ff <= 8'(CS_SETUP_CYC - 1);
            state_ff <= TSP_SETUP;
          end
        end
        TSP_SETUP, TSP_LOW: begin
          if (tmr_out) begin
            sck_ff <= 1'b1;
            if (in_tx) begin
              rx_ff <= {rx_ff[14:0], s_sio};
            end
            tmr_ff <= 8'(SCK_HALF_CYC - 1);
            state_ff <= TSP_HIGH;
          end
        end
        TSP_HIGH: begin
          if (tmr_out) begin
            sck_ff <= 1'b0;
            bit_ff <= bit_nxt;
            tmr_ff <= 8'(SCK_HALF_CYC - 1);
            if (last_bit) begin
              oe_n_ff <= 1'b1;
              state_ff <= TSP_END;
            end else begin
              if (bit_nxt >= 6'(WORD_BITS)) begin
                out_ff <= wword[4'd15 - wsel];
                oe_n_ff <= 1'b0;
              end
              state_ff <= TSP_LOW;
            end
          end
        end
        TSP_END: begin
          if (tmr_out) begin
            cs_n_ff <= 1'b1;
            rxd_ff <= rx_ff;
            state_ff <= TSP_IDLE;
          end
        end
        default: state_ff <= TSP_IDLE;
      endcase
    end
  end

  assign rdata = rdata_ff;
  assign link.cs_n = cs_n_ff;
  assign link.serial_clock_in = sck_ff;
  assign link.mst_sio_out = out_ff;
  assign link.mst_sio_oe_n = oe_n_ff;
endmodule // tsp_master

// ### design/tsp_pkg.sv
// Purpose: Shared constants for the serial temperature sensor port.
// Assumes: 100 MHz system clock on both ends.
// Notes: Timing counts are derived from times in nanoseconds.
//
// Functional notes
// - Reset loads temperature word with FF00.
// - Conversions run continuously after reset.
// - Result in bits 15..3, bit 2 high.
// - Bit 2 is the conversion-complete flag.
// - Result changes only when a conversion completes.
// - Output on falling edge, sample on rising.
// - Frame: 16 transmit clocks, 16 receive clocks.
// - Data pin released while select is high.
// - Master lowers select only while clock low.
// - First bit driven when select falls.
// - Release data pin after fourteen bits.
// - Select may rise anytime; frame ends cleanly.
// - Shift register reloads only while select high.
// - Last eight received bits form mode code.
// - All ones means shutdown, else convert.
// - Master sends only the listed mode codes; tsp_master sends any byte written to REG_MODE.
// - Master can read ident inside one frame.
// - After shutdown, stale value until fresh conversion.
// - Temperature is 13-bit two's complement, 1/16 C.
// - Most significant bit is sent first.
// - Serial port works during shutdown.
// - Shutdown returns a fixed identification word.
package tsp_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned TX_DRIVE_BITS = 14;
  localparam int unsigned RX_BITS = 8;
  localparam int unsigned TEMP_MSB = 15;
  localparam int unsigned TEMP_LSB = 3;
  localparam int unsigned DONE_BIT = 2;
  localparam logic [15:0] TEMP_POR = 16'hFF00;
  // Identification value is arbitrary.
  localparam logic [15:0] IDENT_DEF = 16'h3000;
  localparam logic [7:0] SHUTDOWN_CODE = 8'hFF;
  localparam logic [7:0] CONVERT_CODE = 8'h00;
  // Conversion period is not fixed by the link; a plain default.
  localparam int unsigned CONV_NS = 100000;
  localparam int unsigned CONV_DEF_CYCLES = CONV_NS / CLK_NS;
  localparam int unsigned SCK_MIN_NS = 160;
  localparam int unsigned SCK_HALF_CYC =
    (SCK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CS_SETUP_NS = 100;
  localparam int unsigned CS_SETUP_CYC = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  // Master register map.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_RXD = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_FULL = 1;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  typedef enum {TSP_IDLE, TSP_SETUP, TSP_HIGH, TSP_LOW, TSP_END} tsp_state_t;
endpackage

// ### design/tsp_sensor.sv
// Purpose: Sensor end of the three-wire link with result register.
// Assumes: Link clock is slow enough to be sampled by clk.
// Notes: The converter itself lies outside; adc_code is its output.
`timescale 1ns/1ns
module tsp_sensor #(
  parameter int unsigned CONV_CYCLES = tsp_pkg::CONV_DEF_CYCLES,
  parameter logic [15:0] IDENT_WORD = tsp_pkg::IDENT_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [12:0] adc_code,
  tsp_if.device link,
  output logic mode_shutdown,
  output logic [15:0] temp_word
);
  import tsp_pkg::*;

  logic s_cs_n;
  logic s_sck;
  logic s_sio;
  logic sck_prev_ff;
  logic cs_prev_ff;
  logic [31:0] conv_cnt_ff;
  logic [15:0] temp_ff;
  logic [15:0] tx_ff;
  logic sio_out_ff;
  logic sio_oe_n_ff;
  logic [5:0] clk_cnt_ff;
  logic [7:0] rx_ff;
  logic [3:0] rx_cnt_ff;
  logic shutdown_ff;

  // Reset values match the idle pins: select high, clock low, pull-up.
  tsp_sync #(.W(3), .INIT(3'b101)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .d({link.cs_n, link.serial_clock_in, link.sio_level}),
    .q({s_cs_n, s_sck, s_sio})
  );

  wire cs_fall = !s_cs_n && cs_prev_ff;
  wire cs_rise = s_cs_n && !cs_prev_ff;
  wire sck_rise = !s_cs_n && s_sck && !sck_prev_ff;
  wire sck_fall = !s_cs_n && !s_sck && sck_prev_ff;
  wire in_rx = clk_cnt_ff >= 6'(WORD_BITS);
  wire tx_done = clk_cnt_ff >= 6'(TX_DRIVE_BITS);
  wire conv_end = !shutdown_ff &&
                  conv_cnt_ff == 32'(CONV_CYCLES - 1);
  wire code_ready = rx_cnt_ff == 4'(RX_BITS);
  wire [15:0] fresh = {adc_code, 1'b1, 2'b00};
  wire [15:0] tx_src = shutdown_ff ? IDENT_WORD : temp_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end else if (ce) begin
      sck_prev_ff <= s_sck;
      cs_prev_ff <= s_cs_n;
    end
  end

  // Conversion timer; shutdown restarts it so a fresh conversion
  // must run in full before the result changes again.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_cnt_ff <= '0;
    end else if (ce) begin
      if (shutdown_ff || conv_end) begin
        conv_cnt_ff <= '0;
      end else begin
        conv_cnt_ff <= conv_cnt_ff + 32'd1;
      end
    end
  end

  // Result register; the done flag stays low until the first update.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp_ff <= TEMP_POR;
    end else if (ce && conv_end) begin
      temp_ff <= fresh;
    end
  end

  // Mode takes effect only at the end of a frame.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shutdown_ff <= 1'b0;
    end else if (ce && cs_rise && code_ready) begin
      shutdown_ff <= rx_ff == SHUTDOWN_CODE;
    end
  end

  // Output shift register follows the source only while deselected,
  // so a conversion ending mid-frame cannot corrupt the bits sent.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_ff <= TEMP_POR;
    end else if (ce) begin
      if (s_cs_n) begin
        tx_ff <= tx_src;
      end else if (sck_fall && !tx_done) begin
        tx_ff <= {tx_ff[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sio_out_ff <= 1'b0;
      sio_oe_n_ff <= 1'b1;
    end else if (ce) begin
      if (s_cs_n) begin
        sio_oe_n_ff <= 1'b1;
      end else if (cs_fall) begin
        sio_out_ff <= tx_ff[15];
        sio_oe_n_ff <= 1'b0;
      end else if (sck_fall) begin
        if (tx_done) begin
          sio_oe_n_ff <= 1'b1;
        end else begin
          sio_out_ff <= tx_ff[14];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_cnt_ff <= '0;
    end else if (ce) begin
      if (cs_fall) begin
        clk_cnt_ff <= '0;
      end else if (sck_rise && clk_cnt_ff != 6'(FRAME_BITS)) begin
        clk_cnt_ff <= clk_cnt_ff + 6'd1;
      end
    end
  end

  // Receive shifter; the serial port runs the same in shutdown.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_ff <= CONVERT_CODE;
      rx_cnt_ff <= '0;
    end else if (ce) begin
      if (cs_fall) begin
        rx_cnt_ff <= '0;
      end else if (sck_rise && in_rx) begin
        rx_ff <= {rx_ff[6:0], s_sio};
        if (!code_ready) begin
          rx_cnt_ff <= rx_cnt_ff + 4'd1;
        end
      end
    end
  end

  assign link.dev_sio_out = sio_out_ff;
  assign link.dev_sio_oe_n = sio_oe_n_ff;
  assign mode_shutdown = shutdown_ff;
  assign temp_word = temp_ff;
endmodule // tsp_sensor

// ### design/tsp_sync.sv
// Purpose: Two-stage synchroniser for asynchronous inputs.
// Assumes: Inputs are independent single-bit levels.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ns
module tsp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else if (ce) begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule // tsp_sync

// ### dv/tsp_monitor.sv
// Purpose: Concurrent checks on the three-wire link.
// Assumes: Both ends share clk and resetn.
// Notes: Rising link clocks are counted within each frame.
`timescale 1ns/1ns
module tsp_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic serial_clock_in,
  input wire logic dev_sio_out,
  input wire logic dev_sio_oe_n,
  input wire logic mst_sio_oe_n
);
  logic sck_d_ff;
  logic [5:0] rise_cnt_ff;
  logic [5:0] nxt_rise_cnt;
  wire sck_rise = serial_clock_in && !sck_d_ff;
  assign nxt_rise_cnt = cs_n ? 6'h00 : rise_cnt_ff + {5'h00, sck_rise};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_d_ff <= 1'b0;
      rise_cnt_ff <= 6'h00;
    end else begin
      sck_d_ff <= serial_clock_in;
      rise_cnt_ff <= nxt_rise_cnt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_idle_release;
    cs_n [*6] |-> dev_sio_oe_n;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("data pin driven while select high");
  property p_first_bit;
    $fell(cs_n) |-> ##[1:6] !dev_sio_oe_n;
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first bit not driven after select fell");
  property p_cs_clock_low;
    $fell(cs_n) |-> !serial_clock_in;
  endproperty
  a_cs_clock_low: assert property (p_cs_clock_low)
    else $error("select fell with link clock high");
  property p_setup;
    $rose(serial_clock_in) |-> !cs_n && !$past(cs_n, 8);
  endproperty
  a_setup: assert property (p_setup)
    else $error("link clock rose too soon after select");
  property p_out_on_fall;
    !dev_sio_oe_n && !$past(dev_sio_oe_n) && $changed(dev_sio_out)
      |-> !serial_clock_in;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)
    else $error("sensor data changed while clock high");
  property p_drive_window;
    !cs_n && serial_clock_in && rise_cnt_ff inside {[6'h01:6'h0D]}
      |-> !dev_sio_oe_n;
  endproperty
  a_drive_window: assert property (p_drive_window)
    else $error("sensor released data pin too early");
  property p_release_after;
    !cs_n && rise_cnt_ff >= 6'h0F |-> dev_sio_oe_n;
  endproperty
  a_release_after: assert property (p_release_after)
    else $error("sensor still drives after fourteen bits");
  property p_frame_len;
    $rose(cs_n) |-> rise_cnt_ff inside {6'h10, 6'h20};
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length not 16 or 32 clocks");
  property p_master_rx_phase;
    !mst_sio_oe_n && !cs_n |-> rise_cnt_ff >= 6'h10;
  endproperty
  a_master_rx_phase: assert property (p_master_rx_phase)
    else $error("master drove pin in transmit phase");
endmodule // tsp_monitor

// ### dv/tsp_tb_top.sv
// Purpose: Drives both link ends through the master register port.
// Assumes: Conversion period cut to 50 clocks to keep the run short.
// Notes: Released bits 1:0 read back as ones through the pull-up.
`timescale 1ns/1ns
module tsp_tb_top;
  import tsp_pkg::*;
  localparam int CONV = 50;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [12:0] adc_code = 13'h0000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic shut;
  logic [15:0] tword;
  logic [31:0] d;
  logic [15:0] old;
  logic [12:0] corner [3] = '{13'h0FFF, 13'h1000, 13'h1FFF};
  int fails = 0;
  int checked = 0;
  tsp_if lnk();
  tsp_sensor #(.CONV_CYCLES(CONV)) u_tsp_sensor (.clk(clk),
    .resetn(resetn), .ce(ce), .adc_code(adc_code), .link(lnk),
    .mode_shutdown(shut), .temp_word(tword));
  tsp_master u_tsp_master (.clk(clk), .resetn(resetn), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .link(lnk));
  tsp_monitor u_tsp_monitor (.clk(clk), .resetn(resetn),
    .cs_n(lnk.cs_n), .serial_clock_in(lnk.serial_clock_in),
    .dev_sio_out(lnk.dev_sio_out), .dev_sio_oe_n(lnk.dev_sio_oe_n),
    .mst_sio_oe_n(lnk.mst_sio_oe_n));
  always #5 clk = ~clk;
  function automatic logic [15:0] rx_word(input logic [15:0] w);
    return {w[15:2], 2'b11};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // A full frame also sends the mode byte; a short one only reads.
  task automatic frame(input logic [7:0] code, input logic full);
    if (full) reg_wr(REG_MODE, {24'h00_0000, code});
    reg_wr(REG_CTRL, {30'h0000_0000, full, 1'b1});
    d = 32'h0000_0000;
    for (int i = 0; i < 600 && d[STAT_DONE] !== 1'b1; i++)
      reg_rd(REG_STAT, d);
    check(d[STAT_DONE], 1'b1);
    // The sensor sees select rise through its synchroniser, so the new
    // mode lands a few clocks after the master reports done.
    repeat (4) @(posedge clk);
  endtask
  initial begin
    void'($urandom(52));
    adc_code <= 13'($urandom);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check(tword, TEMP_POR);
    check(shut, 1'b0);
    frame(8'h00, 1'b0);
    reg_rd(REG_RXD, d);
    check(d, {16'h0000, rx_word(TEMP_POR)});
    check(tword, {adc_code, 3'b100});
    reg_wr(8'h10, 32'hFFFF_FFFF);
    reg_rd(8'h10, d);
    check(d, 32'h0000_0000);
    for (int k = 0; k < 7; k++) begin
      adc_code <= (k < 3) ? corner[k] : 13'($urandom);
      repeat (2 * CONV) @(posedge clk);
      frame(8'h00, 1'b0);
      reg_rd(REG_RXD, d);
      check(d[15:0], rx_word({adc_code, 3'b100}));
    end
    for (int k = 0; k < 8; k++) begin
      repeat (2 * CONV) @(posedge clk);
      old = tword;
      frame(SHUTDOWN_CODE, 1'b1);
      check(shut, 1'b1);
      adc_code <= 13'($urandom);
      frame(8'h00, 1'b0);
      reg_rd(REG_RXD, d);
      check(d[15:0], rx_word(IDENT_DEF));
      check(tword, old);
      frame(8'((16'h0001 << k) - 1), 1'b1);
      check(shut, 1'b0);
      check(tword, old);
      repeat (CONV + 10) @(posedge clk);
      check(tword, {adc_code, 3'b100});
    end
    frame(SHUTDOWN_CODE, 1'b1);
    reg_wr(REG_CTRL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check(tword, TEMP_POR);
    check(shut, 1'b0);
    frame(8'h00, 1'b0);
    reg_rd(REG_RXD, d);
    check(d[DONE_BIT], 1'b0);
    conclude();
  end
  initial begin
    #1000000;
    fails++;
    conclude();
  end
endmodule // tsp_tb_top
